// *** verilog/bhp_pkg.sv ***
// Shared constants, types and helpers for the buffer memory host port.
package bhp_pkg;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 12;
	localparam int OPC_LSB = 12;
	localparam int OPC_W = 4;
	localparam int FIFO_DEPTH = 16;
	localparam logic [DATA_W-1:0] COUNT_FULL = 16'hFFFF;
	localparam logic [OPC_W-1:0] OPC_NOP = 4'h0;
	localparam logic [OPC_W-1:0] OPC_LOAD_PTR = 4'h1;
	localparam logic [OPC_W-1:0] OPC_START_TIMED = 4'h2;
	localparam logic [OPC_W-1:0] OPC_START_UNTIMED = 4'h3;
	localparam logic [OPC_W-1:0] OPC_STOP = 4'h4;
	localparam logic [OPC_W-1:0] OPC_CLEAR = 4'h5;
	// Clock and link timing, in nanoseconds and in clock cycles.
	localparam int CLK_PERIOD_NS = 10;
	localparam int READ_PULSE_NS = 1000;
	localparam int CMD_PULSE_NS = 200;
	localparam int CMD_HOLD_NS = 100;
	localparam int READ_PULSE_CYC = READ_PULSE_NS / CLK_PERIOD_NS;
	localparam int CMD_PULSE_CYC =
		(CMD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CMD_HOLD_CYC =
		(CMD_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMER_UNIT_CYC = 100000;
	localparam int TIMER_W = 32;
	localparam int CNT_W = 16;
	typedef enum logic [1:0] {DS_IDLE, DS_READ, DS_INC, DS_CLEAR}
		bhp_dev_state_type;
	typedef enum logic [1:0] {HS_IDLE, HS_READ, HS_CMD, HS_HOLD}
		bhp_host_state_type;
	typedef enum logic [1:0] {ACC_OFF, ACC_TIMED, ACC_UNTIMED}
		bhp_acc_mode_type;

	// A pin bit moves only once the second and third stages agree.
	function automatic logic [DATA_W-1:0] bhp_settle(
		input logic [DATA_W-1:0] s2,
		input logic [DATA_W-1:0] s3,
		input logic [DATA_W-1:0] f);
		return (s2 & ~(s2 ^ s3)) | (f & (s2 ^ s3));
	endfunction
endpackage

// *** verilog/bhp_link_if.sv ***
// Parallel link between the buffer memory and the host I/O card.
`timescale 1ns/1ps
interface bhp_link_if;
	import bhp_pkg::*;
	logic [DATA_W-1:0] read_data;
	logic [DATA_W-1:0] cmd_data;
	logic word_read_strobe;
	logic cmd_strobe;
	logic service_req;

	// The buffer memory end.
	modport device_mp(
		output read_data,
		output service_req,
		input cmd_data,
		input word_read_strobe,
		input cmd_strobe
	);

	// The host I/O card end.
	modport host_mp(
		input read_data,
		input service_req,
		output cmd_data,
		output word_read_strobe,
		output cmd_strobe
	);
endinterface

// *** verilog/bhp_fifo.sv ***
// Parameterised first-in first-out queue with valid and ready on each side.
`timescale 1ns/1ps
module bhp_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 16
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	import bhp_pkg::*;
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	typedef struct packed {
		logic [AW-1:0] wptr;
		logic [AW-1:0] rptr;
		logic [AW:0] count;
		logic ready;
	} bhp_fifo_reg_type;
	bhp_fifo_reg_type q;
	bhp_fifo_reg_type d;
	logic [WIDTH-1:0] store [0:DEPTH-1];
	logic push;
	logic pop;

	assign out_valid = (q.count != '0);
	assign out_data = store[q.rptr];
	assign in_ready = q.ready;
	assign push = in_valid & q.ready;
	assign pop = out_valid & out_ready;

	// Pointers wrap at DEPTH so that depths other than powers of two work.
	always_comb begin
		d = q;
		if (push) begin
			d.wptr = (q.wptr == AW'(DEPTH - 1)) ? '0 : q.wptr + 1'b1;
		end
		if (pop) begin
			d.rptr = (q.rptr == AW'(DEPTH - 1)) ? '0 : q.rptr + 1'b1;
		end
		d.count = q.count + (AW + 1)'(push) - (AW + 1)'(pop);
		d.ready = (d.count != (AW + 1)'(DEPTH));
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			q <= '{wptr: '0, rptr: '0, count: '0, ready: 1'b1};
		end else begin
			q <= d;
		end
	end

	// Storage holds no reset; only written slots are ever read.
	always_ff @(posedge clock) begin
		if (push) begin
			store[q.wptr] <= in_data;
		end
	end
endmodule // bhp_fifo

// *** verilog/bhp_device.sv ***
// Buffer memory end of the host port: channel store, reads and commands.
`timescale 1ns/1ps
module bhp_device #(
	parameter int ADDR_BITS = bhp_pkg::ADDR_W,
	parameter int QUEUE_DEPTH = bhp_pkg::FIFO_DEPTH,
	parameter int UNIT_CYC = bhp_pkg::TIMER_UNIT_CYC
) (
	input wire logic clock,
	input wire logic rst_n,
	bhp_link_if.device_mp link,
	input wire logic hit_valid,
	output logic hit_ready,
	input wire logic [ADDR_BITS-1:0] hit_channel,
	output logic [bhp_pkg::DATA_W-1:0] cmd_word,
	output logic cmd_valid
);
	import bhp_pkg::*;
	localparam int CHANNELS = 1 << ADDR_BITS;
	localparam int STB_RD = 0;
	localparam int STB_CMD = 1;

	typedef struct packed {
		logic [1:0] stb1;
		logic [1:0] stb2;
		logic [1:0] stb3;
		logic [1:0] stb_f;
		logic [DATA_W-1:0] cd1;
		logic [DATA_W-1:0] cd2;
		logic [DATA_W-1:0] cd3;
		logic [DATA_W-1:0] cd_f;
		logic rd_pend;
		logic clr_pend;
		bhp_dev_state_type state;
		logic [ADDR_BITS-1:0] ptr;
		logic [ADDR_BITS-1:0] chan;
		logic count_it;
		logic [DATA_W-1:0] rdata;
		logic srq;
		bhp_acc_mode_type mode;
		logic [TIMER_W-1:0] timer;
		logic [DATA_W-1:0] cmd_word;
		logic cmd_valid;
	} bhp_dev_reg_type;

	bhp_dev_reg_type q;
	bhp_dev_reg_type d;
	logic [DATA_W-1:0] mem [0:CHANNELS-1];
	logic [DATA_W-1:0] mem_q;
	logic [ADDR_BITS-1:0] mem_addr;
	logic [DATA_W-1:0] mem_wdata;
	logic mem_we;
	logic fifo_valid;
	logic fifo_pop;
	logic [ADDR_BITS-1:0] fifo_chan;
	logic rd_rise;
	logic cmd_fall;
	logic srq_set;
	logic [DATA_W-1:0] inc_val;
	logic [OPC_W-1:0] opcode;

	// Hits queue here while the store is busy serving a host read, so
	// a read is never held up by more than one increment in flight.
	bhp_fifo #(
		.WIDTH(ADDR_BITS),
		.DEPTH(QUEUE_DEPTH)
	) u_hit_fifo (
		.clock(clock),
		.rst_n(rst_n),
		.in_valid(hit_valid),
		.in_ready(hit_ready),
		.in_data(hit_channel),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_chan)
	);

	assign inc_val = mem_q + 1'b1;
	assign opcode = q.cd_f[OPC_LSB +: OPC_W];

	// Next-state logic for synchronisers, access engine and commands.
	always_comb begin
		d = q;
		mem_we = 1'b0;
		mem_addr = q.ptr;
		mem_wdata = '0;
		fifo_pop = 1'b0;
		srq_set = 1'b0;
		d.cmd_valid = 1'b0;
		// Both strobes and the command bus come from the host's pins.
		d.stb1 = {link.cmd_strobe, link.word_read_strobe};
		d.stb2 = q.stb1;
		d.stb3 = q.stb2;
		d.stb_f = 2'(bhp_settle(DATA_W'(q.stb2), DATA_W'(q.stb3),
			DATA_W'(q.stb_f)));
		d.cd1 = link.cmd_data;
		d.cd2 = q.cd1;
		d.cd3 = q.cd2;
		d.cd_f = bhp_settle(q.cd2, q.cd3, q.cd_f);
		rd_rise = d.stb_f[STB_RD] & ~q.stb_f[STB_RD];
		cmd_fall = ~d.stb_f[STB_CMD] & q.stb_f[STB_CMD];

		// Timed accumulation counts down and raises the request once the timer is down to one.
		if (q.mode == ACC_TIMED) begin
			if (q.timer <= TIMER_W'(1)) begin
				d.mode = ACC_OFF;
				srq_set = 1'b1;
			end else begin
				d.timer = q.timer - 1'b1;
			end
		end

		// Single-port store: host reads first, then clearing, then hits.
		unique case (q.state)
			DS_IDLE: begin
				if (q.rd_pend) begin
					d.rd_pend = 1'b0;
					mem_addr = q.ptr;
					d.state = DS_READ;
				end else if (q.clr_pend) begin
					d.clr_pend = 1'b0;
					d.chan = '0;
					d.state = DS_CLEAR;
				end else if (fifo_valid) begin
					fifo_pop = 1'b1;
					mem_addr = fifo_chan;
					d.chan = fifo_chan;
					d.count_it = (q.mode != ACC_OFF);
					d.state = DS_INC;
				end
			end
			DS_READ: begin
				d.rdata = mem_q;
				d.ptr = q.ptr + 1'b1;
				d.state = DS_IDLE;
			end
			DS_INC: begin
				mem_addr = q.chan;
				// Counts saturate so a full channel never rolls to zero.
				if (q.count_it && mem_q != COUNT_FULL) begin
					mem_we = 1'b1;
					mem_wdata = inc_val;
					if (inc_val == COUNT_FULL && q.mode == ACC_UNTIMED) begin
						srq_set = 1'b1;
					end
				end
				d.state = DS_IDLE;
			end
			DS_CLEAR: begin
				mem_addr = q.chan;
				mem_we = 1'b1;
				d.chan = q.chan + 1'b1;
				if (q.chan == ADDR_BITS'(CHANNELS - 1)) begin
					d.state = DS_IDLE;
				end
			end
		endcase

		// Set after the engine so a strobe in the serving cycle survives.
		if (rd_rise) begin
			d.rd_pend = 1'b1;
		end

		// Command word is taken once the strobe has settled low.
		if (cmd_fall) begin
			d.cmd_word = q.cd_f;
			d.cmd_valid = 1'b1;
			d.srq = 1'b0;
			case (opcode)
				OPC_LOAD_PTR: d.ptr = q.cd_f[ADDR_BITS-1:0];
				OPC_START_TIMED: begin
					d.mode = ACC_TIMED;
					d.timer = TIMER_W'(q.cd_f[OPC_LSB-1:0]) *
						TIMER_W'(UNIT_CYC);
				end
				OPC_START_UNTIMED: d.mode = ACC_UNTIMED;
				OPC_STOP: d.mode = ACC_OFF;
				OPC_CLEAR: d.clr_pend = 1'b1;
				default: d.mode = q.mode;
			endcase
		end

		// A new event beats a clearing command in the same cycle.
		if (srq_set) begin
			d.srq = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Channel store; contents are undefined until a clear command runs.
	always_ff @(posedge clock) begin
		if (mem_we) begin
			mem[mem_addr] <= mem_wdata;
		end
		mem_q <= mem[mem_addr];
	end

	// Link outputs, cmd_word and cmd_valid come straight from the state register; hit_ready comes from the queue.
	assign link.read_data = q.rdata;
	assign link.service_req = q.srq;
	assign cmd_word = q.cmd_word;
	assign cmd_valid = q.cmd_valid;
endmodule // bhp_device

// *** verilog/bhp_host.sv ***
// Host I/O card end of the link: pulses strobes and watches the request.
`timescale 1ns/1ps
module bhp_host #(
	parameter int READ_CYC = bhp_pkg::READ_PULSE_CYC,
	parameter int CMD_CYC = bhp_pkg::CMD_PULSE_CYC,
	parameter int HOLD_CYC = bhp_pkg::CMD_HOLD_CYC
) (
	input wire logic clock,
	input wire logic rst_n,
	bhp_link_if.host_mp link,
	input wire logic rd_req,
	input wire logic cmd_req,
	input wire logic [bhp_pkg::DATA_W-1:0] cmd_in,
	input wire logic irq_enable,
	output logic busy,
	output logic [bhp_pkg::DATA_W-1:0] rd_word,
	output logic rd_valid,
	output logic srq_flag,
	output logic srq_irq
);
	import bhp_pkg::*;
	typedef struct packed {
		logic [DATA_W-1:0] rd1;
		logic [DATA_W-1:0] rd2;
		logic [DATA_W-1:0] rd3;
		logic [DATA_W-1:0] rd_f;
		logic [2:0] sr;
		logic sr_f;
		bhp_host_state_type state;
		logic [CNT_W-1:0] cnt;
		logic strobe_rd;
		logic strobe_cmd;
		logic [DATA_W-1:0] cmd_out;
		logic busy;
		logic [DATA_W-1:0] rd_word;
		logic rd_valid;
		logic srq_irq;
	} bhp_host_reg_type;
	bhp_host_reg_type q;
	bhp_host_reg_type d;

	// One pulse at a time: read strobe or command strobe, each then a hold.
	always_comb begin
		d = q;
		d.rd_valid = 1'b0;
		d.srq_irq = 1'b0;
		d.rd1 = link.read_data;
		d.rd2 = q.rd1;
		d.rd3 = q.rd2;
		d.rd_f = bhp_settle(q.rd2, q.rd3, q.rd_f);
		d.sr = {q.sr[1:0], link.service_req};
		d.sr_f = 1'(bhp_settle(DATA_W'(q.sr[1]), DATA_W'(q.sr[2]),
			DATA_W'(q.sr_f)));
		// Software picks polling or interrupt by the enable input.
		if (d.sr_f && !q.sr_f && irq_enable) begin
			d.srq_irq = 1'b1;
		end
		unique case (q.state)
			HS_IDLE: begin
				if (rd_req) begin
					d.strobe_rd = 1'b1;
					d.cnt = CNT_W'(READ_CYC - 1);
					d.busy = 1'b1;
					d.state = HS_READ;
				end else if (cmd_req) begin
					d.cmd_out = cmd_in;
					d.strobe_cmd = 1'b1;
					d.cnt = CNT_W'(CMD_CYC - 1);
					d.busy = 1'b1;
					d.state = HS_CMD;
				end
			end
			HS_READ: begin
				if (q.cnt == '0) begin
					d.strobe_rd = 1'b0;
					d.rd_word = q.rd_f;
					d.rd_valid = 1'b1;
					d.cnt = CNT_W'(HOLD_CYC - 1);
					d.state = HS_HOLD;
				end else begin
					d.cnt = q.cnt - 1'b1;
				end
			end
			HS_CMD: begin
				if (q.cnt == '0) begin
					d.strobe_cmd = 1'b0;
					d.cnt = CNT_W'(HOLD_CYC - 1);
					d.state = HS_HOLD;
				end else begin
					d.cnt = q.cnt - 1'b1;
				end
			end
			HS_HOLD: begin
				// Command data stays put so the falling edge sees it stable.
				if (q.cnt == '0) begin
					d.busy = 1'b0;
					d.state = HS_IDLE;
				end else begin
					d.cnt = q.cnt - 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign link.word_read_strobe = q.strobe_rd;
	assign link.cmd_strobe = q.strobe_cmd;
	assign link.cmd_data = q.cmd_out;
	assign busy = q.busy;
	assign rd_word = q.rd_word;
	assign rd_valid = q.rd_valid;
	assign srq_flag = q.sr_f;
	assign srq_irq = q.srq_irq;
endmodule // bhp_host

// *** tb/bhp_link_props.sv ***
// Timing checks on the parallel link between the two ends.
`timescale 1ns/1ps
module bhp_link_props #(
	parameter int RD = 20,
	parameter int CM = 20
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [15:0] read_data,
	input wire logic [15:0] cmd_data,
	input wire logic word_read_strobe,
	input wire logic cmd_strobe,
	input wire logic service_req
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Pulse widths are exact, so a short read pulse starves the fetch.
	a_read_pulse_width: assert property ($fell(word_read_strobe) |->
		$past(word_read_strobe, RD) && !$past(word_read_strobe, RD + 1))
		else $error("read pulse width wrong");
	a_cmd_pulse_width: assert property ($fell(cmd_strobe) |->
		$past(cmd_strobe, CM) && !$past(cmd_strobe, CM + 1))
		else $error("command pulse width wrong");
	a_strobes_exclusive: assert property (
		!(word_read_strobe && cmd_strobe))
		else $error("both strobes high");
	a_strobe_gap: assert property ($fell(word_read_strobe) |->
		!(word_read_strobe || cmd_strobe) [*4])
		else $error("strobe gap too short");
	a_cmd_data_steady: assert property (cmd_strobe && $past(cmd_strobe)
		|-> $stable(cmd_data))
		else $error("command data moved in pulse");
	a_cmd_data_hold: assert property ($fell(cmd_strobe) |->
		$stable(cmd_data) [*4])
		else $error("command data moved after fall");
	a_data_in_pulse: assert property ($changed(read_data) |->
		word_read_strobe)
		else $error("read data moved outside pulse");
	a_srq_cleared: assert property ($fell(service_req) |-> !cmd_strobe &&
		($past(cmd_strobe, 3) || $past(cmd_strobe, 5) ||
		$past(cmd_strobe, 4) || $past(cmd_strobe, 6)))
		else $error("request dropped without command");
endmodule // bhp_link_props

// *** tb/buffer_memory_host_port_bench.sv ***
// Bench joining both ends of the host port over one link.
`timescale 1ns/1ps
module buffer_memory_host_port_bench;
	import bhp_pkg::*;
	logic clock = 0;
	logic rst_n = 0;
	logic hit_valid = 0;
	logic [ADDR_W-1:0] hit_channel = '0;
	logic rd_req = 0;
	logic cmd_req = 0;
	logic [DATA_W-1:0] cmd_in = '0;
	logic irq_enable = 0;
	logic hit_ready, cmd_valid, busy, rd_valid, srq_flag, srq_irq;
	logic [DATA_W-1:0] cmd_word, rd_word;
	int n_errors = 0;
	int samples_checked = 0;
	int n_irq = 0;
	int n_pulse = 0;
	int n_sent = 0;
	int refused;
	int cnt [int];
	int chs [3] = '{4094, 4095, 0};
	bhp_link_if link ();
	bhp_device #(.UNIT_CYC(10)) bhp_device_i (.clock(clock),
		.rst_n(rst_n), .link(link), .hit_valid(hit_valid),
		.hit_ready(hit_ready), .hit_channel(hit_channel),
		.cmd_word(cmd_word), .cmd_valid(cmd_valid));
	bhp_host #(.READ_CYC(20)) bhp_host_i (.clock(clock), .rst_n(rst_n),
		.link(link), .rd_req(rd_req), .cmd_req(cmd_req), .cmd_in(cmd_in),
		.irq_enable(irq_enable), .busy(busy), .rd_word(rd_word),
		.rd_valid(rd_valid), .srq_flag(srq_flag), .srq_irq(srq_irq));
	bhp_link_props #(.RD(20), .CM(CMD_PULSE_CYC)) bhp_link_props_i (
		.clock(clock), .rst_n(rst_n), .read_data(link.read_data),
		.cmd_data(link.cmd_data), .word_read_strobe(link.word_read_strobe),
		.cmd_strobe(link.cmd_strobe), .service_req(link.service_req));

	// Free-running clock at 100 MHz.
	always #5 clock = ~clock;

	// Interrupt pulses are counted so masking can be judged, and answer
	// pulses so that every request is seen to earn exactly one.
	always @(posedge clock) begin
		if (srq_irq === 1'b1) n_irq++;
		if (rd_valid === 1'b1 || cmd_valid === 1'b1) n_pulse++;
	end

	task automatic chk(input string what, input logic [DATA_W-1:0] seen,
		input logic [DATA_W-1:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// One host request, returning once the port is idle again.
	task automatic op(input logic r, input logic [DATA_W-1:0] w);
		@(posedge clock);
		#1;
		rd_req = r;
		cmd_req = !r;
		cmd_in = w;
		n_sent++;
		@(posedge clock);
		#1;
		rd_req = 0;
		cmd_req = 0;
		while (busy !== 1'b0) begin
			@(posedge clock);
			#1;
		end
		chk("answer pulses", DATA_W'(n_pulse), DATA_W'(n_sent));
	endtask

	// Valid stays up between hits, so it is lowered by the caller.
	task automatic hit(input logic [ADDR_W-1:0] ch);
		hit_valid = 1;
		hit_channel = ch;
		@(posedge clock);
		while (hit_ready !== 1'b1) @(posedge clock);
		#1;
	endtask

	function automatic logic [DATA_W-1:0] exp_cnt(int ch);
		return cnt.exists(ch) ? DATA_W'(cnt[ch]) : 16'h0000;
	endfunction

	// Main sequence of tests.
	initial begin
		void'($urandom(32'hF5AFB80E));
		repeat (8) @(posedge clock);
		#1 rst_n = 1;
		chk("hit_ready", DATA_W'(hit_ready), 16'h0001);
		chk("service_req", DATA_W'(link.service_req), 16'h0000);
		$display("test reset done");
		op(0, 16'h3000);
		op(0, 16'h5000);
		refused = 0;
		hit_channel = 12'h005;
		hit_valid = 1;
		for (int i = 0; i < 40; i++) begin
			@(posedge clock);
			#1;
			if (hit_ready !== 1'b1) refused = 1;
		end
		hit_valid = 0;
		chk("queue full", DATA_W'(refused), 16'h0001);
		repeat (4200) @(posedge clock);
		op(0, 16'h4000);
		op(0, 16'h5000);
		repeat (4200) @(posedge clock);
		$display("test queue done");
		op(0, 16'h3000);
		for (int i = 0; i < 3; i++) begin
			cnt[chs[i]] = $urandom_range(1, 5);
			repeat (cnt[chs[i]]) hit(ADDR_W'(chs[i]));
		end
		hit_valid = 0;
		repeat (40) @(posedge clock);
		op(0, 16'h4000);
		hit(12'h001);
		hit_valid = 0;
		op(0, 16'h1FFE);
		chk("cmd_word", cmd_word, 16'h1FFE);
		chk("cmd_data", link.cmd_data, 16'h1FFE);
		for (int i = 0; i < 4; i++) begin
			logic [DATA_W-1:0] want;
			want = exp_cnt((4094 + i) % 4096);
			op(1, 16'h0000);
			chk("word", rd_word, want);
			chk("read_data", link.read_data, want);
		end
		$display("test reads done");
		for (int e = 1; e >= 0; e--) begin
			irq_enable = e[0];
			n_irq = 0;
			op(0, 16'h2003);
			for (int t = 0; t < 200 && srq_flag !== 1'b1; t++)
				@(posedge clock);
			// Step off the edge so the interrupt counter has settled.
			#1;
			chk("srq_flag", DATA_W'(srq_flag), 16'h0001);
			chk("srq_irq", DATA_W'(n_irq), DATA_W'(e));
			op(0, 16'h0000);
			repeat (4) @(posedge clock);
			#1;
			chk("srq_flag", DATA_W'(srq_flag), 16'h0000);
		end
		$display("test request done");
		wrap_up;
	end

	// Watchdog sized well above the expected run of about 9000 cycles.
	initial begin
		#400000;
		n_errors++;
		wrap_up;
	end
endmodule // buffer_memory_host_port_bench
